// [hdl/pcs_fifo_regs.svh]
// Purpose: offsets, field positions, reset values and counts
// Assumes: included by the fifo control module
// Notes: config registers live at 0x1 to 0xa
`ifndef PCS_FIFO_REGS_SVH
`define PCS_FIFO_REGS_SVH
`define PCS_CFG_FIRST    4'h1
`define PCS_CFG_LAST     4'hA
`define PCS_CFG_AE_LSB   4'h4
`define PCS_CFG_AE_MSB   4'h5
`define PCS_CFG_AF_LSB   4'h7
`define PCS_CFG_AF_MSB   4'h8
`define PCS_CFG_FAST     4'hA
`define PCS_FAST_BIT     7
`define PCS_RST_THRESH   8'h7F
`define PCS_RST_FAST     8'h80
`define PCS_RST_ZERO     8'h00
`define PCS_SETTLE_LAST  3'h7
`define PCS_EVAL_TERM    10'h3FF
`define PCS_RESERVE_LOCS 8
`define PCS_SPI_LAST_BIT 4'hF
`endif

// [hdl/pcs_fifo_pkg.sv]
// Purpose: types for the fifo control block
// Assumes: nothing
// Notes: binary state codes
package pcs_fifo_pkg;
    typedef enum logic [1:0] {
        PCS_EVAL_IDLE  = 2'b00,
        PCS_EVAL_COUNT = 2'b01,
        PCS_EVAL_DONE  = 2'b10
    } pcs_eval_e;
    typedef logic [7:0] pcs_byte_t;
endpackage

// [hdl/pcs_fifo_ctrl.sv]
// Purpose: dual-port fifo control, config access, clock selection
// Assumes: all pins asynchronous to clk, sampled through three flops
// Notes: flags are active high
// Summary of operation
// - serial mode shifts one bit per serial edge
// - serial frame writes any of ten registers
// - write enable stores word per write edge
// - read enable fetches word per read edge
// - parallel config idle: no transfer, no shifting
// - width code selects nine to thirty-six bits
// - depth follows width: 16, 8, 4 Meg
// - eight locations withheld from storage
// - two 10-bit counters run after master reset
// - first counter to terminal picks master clock
// - fast bit one means write clock faster
// - evaluation loads fast bit; software may override
// - config change acts after eight write edges
`timescale 1ns/100ps
`include "pcs_fifo_regs.svh"
module pcs_fifo_ctrl
    import pcs_fifo_pkg::*;
#(
    parameter int DATA_W = 36,
    parameter int AW     = 24
) (
    // system
    input  wire logic              clk,
    input  wire logic              rst,
    // control pins
    input  wire logic              master_reset,
    input  wire logic              wclk,
    input  wire logic              rclk,
    input  wire logic              write_en_n,
    input  wire logic              read_en_n,
    input  wire logic              config_access_n,
    input  wire logic [2:0]        port_width_sel,
    // serial config port
    input  wire logic              serial_clk,
    input  wire logic              serial_select_n,
    input  wire logic              serial_in,
    // data
    input  wire logic [DATA_W-1:0] data_in,
    output logic      [DATA_W-1:0] data_out,
    // status
    output logic                   empty_flag,
    output logic                   full_flag,
    output logic                   prog_almost_empty_flag,
    output logic                   prog_almost_full_flag,
    output logic                   fast_clk_is_write
);
    localparam int PIN_W = DATA_W + 12;

    logic [PIN_W-1:0] pin_raw, s1_reg, s2_reg, s3_reg, pin_reg;
    assign pin_raw = {master_reset, wclk, rclk, write_en_n, read_en_n, config_access_n,
                      port_width_sel, serial_clk, serial_select_n, serial_in, data_in};

    // three-stage sync, change accepted when stages two and three agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= pin_raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end
    for (genvar i = 0; i < PIN_W; i++) begin : g_filt
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                pin_reg[i] <= 1'b0;
            end else if (s2_reg[i] == s3_reg[i]) begin
                pin_reg[i] <= s3_reg[i];
            end
        end
    end

    logic              f_mr, f_wclk, f_rclk, f_wen_n, f_ren_n, f_cfg_n;
    logic              f_sclk, f_sel_n, f_si;
    logic [2:0]        f_pw;
    logic [DATA_W-1:0] f_data;
    assign {f_mr, f_wclk, f_rclk, f_wen_n, f_ren_n, f_cfg_n,
            f_pw, f_sclk, f_sel_n, f_si, f_data} = pin_reg;

    // edge detection
    logic wclk_prev_reg, rclk_prev_reg, sclk_prev_reg, mr_prev_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wclk_prev_reg <= 1'b0;
            rclk_prev_reg <= 1'b0;
            sclk_prev_reg <= 1'b0;
            mr_prev_reg   <= 1'b0;
        end else begin
            wclk_prev_reg <= f_wclk;
            rclk_prev_reg <= f_rclk;
            sclk_prev_reg <= f_sclk;
            mr_prev_reg   <= f_mr;
        end
    end
    logic wclk_rise, rclk_rise, sclk_rise, mr_fall;
    assign wclk_rise = f_wclk & ~wclk_prev_reg;
    assign rclk_rise = f_rclk & ~rclk_prev_reg;
    assign sclk_rise = f_sclk & ~sclk_prev_reg;
    assign mr_fall   = ~f_mr & mr_prev_reg;

    // access mode decode
    logic serial_mode, par_mode, par_wr, par_rd, sclk_shift;
    assign serial_mode = ~f_sel_n & f_cfg_n;
    assign par_mode    = f_sel_n & ~f_cfg_n;
    assign par_wr      = par_mode & ~f_wen_n & f_ren_n & wclk_rise;
    assign par_rd      = par_mode & f_wen_n & ~f_ren_n & rclk_rise;
    assign sclk_shift  = serial_mode & sclk_rise & ~f_mr;

    // width code caught while master reset is high
    logic [2:0] width_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            width_reg <= 3'h7;
        end else if (f_mr) begin
            width_reg <= f_pw;
        end
    end

    logic [DATA_W-1:0] word_mask;
    logic [1:0]        depth_shift;
    always_comb begin
        case (width_reg)
            3'b000:  begin word_mask = DATA_W'(36'h0_0000_01FF); depth_shift = 2'd0; end
            3'b001:  begin word_mask = DATA_W'(36'h0_0000_0FFF); depth_shift = 2'd1; end
            3'b010:  begin word_mask = DATA_W'(36'h0_0000_FFFF); depth_shift = 2'd1; end
            3'b011:  begin word_mask = DATA_W'(36'h0_0003_FFFF); depth_shift = 2'd1; end
            3'b100:  begin word_mask = DATA_W'(36'h0_000F_FFFF); depth_shift = 2'd2; end
            3'b101:  begin word_mask = DATA_W'(36'h0_00FF_FFFF); depth_shift = 2'd2; end
            3'b110:  begin word_mask = DATA_W'(36'h0_FFFF_FFFF); depth_shift = 2'd2; end
            default: begin word_mask = DATA_W'(36'hF_FFFF_FFFF); depth_shift = 2'd2; end
        endcase
    end

    logic [AW:0] cap, limit;
    assign cap   = ((AW+1)'(1) << AW) >> depth_shift;
    assign limit = cap - (AW+1)'(`PCS_RESERVE_LOCS);

    // configuration registers
    pcs_byte_t cfg_reg [1:10];
    pcs_byte_t eff_reg [1:10];

    function automatic pcs_byte_t cfg_default(input int idx);
        if (idx == `PCS_CFG_AE_LSB || idx == `PCS_CFG_AF_LSB) begin
            return `PCS_RST_THRESH;
        end else if (idx == `PCS_CFG_FAST) begin
            return `PCS_RST_FAST;
        end
        return `PCS_RST_ZERO;
    endfunction

    // serial frame: 8 address bits then 8 data bits, msb first
    logic [15:0] spi_sh_reg;
    logic [3:0]  bit_cnt_reg;
    logic [15:0] spi_word;
    logic        spi_commit;
    assign spi_word   = {spi_sh_reg[14:0], f_si};
    assign spi_commit = sclk_shift && bit_cnt_reg == `PCS_SPI_LAST_BIT
                        && spi_word[15:8] >= 8'(`PCS_CFG_FIRST)
                        && spi_word[15:8] <= 8'(`PCS_CFG_LAST);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            spi_sh_reg  <= '0;
            bit_cnt_reg <= '0;
        end else if (f_sel_n) begin
            bit_cnt_reg <= '0;
        end else if (sclk_shift) begin
            spi_sh_reg  <= spi_word;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
    end

    // parallel register pointers, roll back after the tenth
    logic [3:0] par_wptr_reg, par_rptr_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            par_wptr_reg <= `PCS_CFG_FIRST;
            par_rptr_reg <= `PCS_CFG_FIRST;
        end else if (f_cfg_n || f_mr) begin
            par_wptr_reg <= `PCS_CFG_FIRST;
            par_rptr_reg <= `PCS_CFG_FIRST;
        end else begin
            if (par_wr) begin
                par_wptr_reg <= (par_wptr_reg == `PCS_CFG_LAST) ? `PCS_CFG_FIRST
                                : par_wptr_reg + 4'h1;
            end
            if (par_rd) begin
                par_rptr_reg <= (par_rptr_reg == `PCS_CFG_LAST) ? `PCS_CFG_FIRST
                                : par_rptr_reg + 4'h1;
            end
        end
    end

    // clock-rate evaluation after master reset
    pcs_eval_e  eval_reg;
    logic [9:0] wcnt_reg, rcnt_reg;
    logic       w_term, r_term, eval_load;
    assign w_term    = eval_reg == PCS_EVAL_COUNT && wclk_rise && wcnt_reg == `PCS_EVAL_TERM;
    assign r_term    = eval_reg == PCS_EVAL_COUNT && rclk_rise && rcnt_reg == `PCS_EVAL_TERM;
    assign eval_load = w_term | r_term;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            eval_reg <= PCS_EVAL_IDLE;
            wcnt_reg <= '0;
            rcnt_reg <= '0;
        end else if (f_mr) begin
            eval_reg <= PCS_EVAL_IDLE;
            wcnt_reg <= '0;
            rcnt_reg <= '0;
        end else begin
            case (eval_reg)
                PCS_EVAL_IDLE: begin
                    if (mr_fall) eval_reg <= PCS_EVAL_COUNT;
                end
                PCS_EVAL_COUNT: begin
                    if (wclk_rise) wcnt_reg <= wcnt_reg + 10'h1;
                    if (rclk_rise) rcnt_reg <= rcnt_reg + 10'h1;
                    if (eval_load) eval_reg <= PCS_EVAL_DONE;
                end
                PCS_EVAL_DONE: eval_reg <= PCS_EVAL_DONE;
                default:       eval_reg <= PCS_EVAL_IDLE;
            endcase
        end
    end

    // config writes; evaluation result wins over a same-cycle software write
    logic cfg_touch;
    assign cfg_touch = spi_commit | par_wr | eval_load;
    for (genvar r = 1; r <= 10; r++) begin : g_cfg
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                cfg_reg[r] <= cfg_default(r);
            end else if (f_mr) begin
                cfg_reg[r] <= cfg_default(r);
            end else if (r == `PCS_CFG_FAST && eval_load) begin
                cfg_reg[r] <= {w_term, 7'h00};
            end else if (spi_commit && spi_word[11:8] == 4'(r)) begin
                cfg_reg[r] <= spi_word[7:0];
            end else if (par_wr && par_wptr_reg == 4'(r)) begin
                cfg_reg[r] <= f_data[7:0];
            end
        end
    end

    // changes take effect on the eighth write edge after the last write
    logic [2:0] settle_reg;
    logic       pend_reg, settle_done;
    assign settle_done = pend_reg && wclk_rise && settle_reg == `PCS_SETTLE_LAST;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            settle_reg <= '0;
            pend_reg   <= 1'b0;
        end else if (cfg_touch || f_mr) begin
            settle_reg <= '0;
            pend_reg   <= ~f_mr;
        end else if (pend_reg && wclk_rise) begin
            settle_reg <= settle_reg + 3'h1;
            pend_reg   <= ~settle_done;
        end
    end
    for (genvar r = 1; r <= 10; r++) begin : g_eff
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                eff_reg[r] <= cfg_default(r);
            end else if (f_mr) begin
                eff_reg[r] <= cfg_default(r);
            end else if (settle_done) begin
                eff_reg[r] <= cfg_reg[r];
            end
        end
    end
    assign fast_clk_is_write = eff_reg[`PCS_CFG_FAST][`PCS_FAST_BIT];

    // fifo storage and pointers
    logic [DATA_W-1:0] mem [0:(1<<AW)-1];
    logic [AW-1:0]     wr_ptr_reg, rd_ptr_reg;
    logic [AW:0]       count_reg;
    logic              fifo_wr, fifo_rd;
    assign fifo_wr = f_cfg_n & ~f_wen_n & wclk_rise & ~f_mr & (count_reg < limit);
    assign fifo_rd = f_cfg_n & ~f_ren_n & rclk_rise & ~f_mr & (count_reg != '0);

    always_ff @(posedge clk) begin
        if (fifo_wr) mem[wr_ptr_reg] <= f_data & word_mask;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else if (f_mr) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (fifo_wr) begin
                wr_ptr_reg <= ({1'b0, wr_ptr_reg} + 1'b1 == cap) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (fifo_rd) begin
                rd_ptr_reg <= ({1'b0, rd_ptr_reg} + 1'b1 == cap) ? '0 : rd_ptr_reg + 1'b1;
            end
            if (fifo_wr && !fifo_rd) count_reg <= count_reg + 1'b1;
            else if (fifo_rd && !fifo_wr) count_reg <= count_reg - 1'b1;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            data_out <= '0;
        end else if (fifo_rd) begin
            data_out <= mem[rd_ptr_reg] & word_mask;
        end else if (par_rd) begin
            data_out <= DATA_W'(cfg_reg[par_rptr_reg]);
        end
    end

    // status flags from the settled thresholds
    logic [AW:0]    ae_th, af_th;
    logic [AW+10:0] ae_wide, af_wide;
    // thresholds beyond the usable depth clamp instead of wrapping
    assign ae_wide = (AW+11)'({eff_reg[`PCS_CFG_AE_MSB][1:0], eff_reg[`PCS_CFG_AE_LSB]});
    assign af_wide = (AW+11)'(limit)
                     - (AW+11)'({eff_reg[`PCS_CFG_AF_MSB][1:0], eff_reg[`PCS_CFG_AF_LSB]});
    assign ae_th   = (ae_wide > (AW+11)'(limit)) ? limit : ae_wide[AW:0];
    assign af_th   = af_wide[AW+10] ? '0 : af_wide[AW:0];
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            empty_flag             <= 1'b1;
            full_flag              <= 1'b0;
            prog_almost_empty_flag <= 1'b1;
            prog_almost_full_flag  <= 1'b0;
        end else begin
            empty_flag             <= count_reg == '0;
            full_flag              <= count_reg >= limit;
            prog_almost_empty_flag <= count_reg <= ae_th;
            prog_almost_full_flag  <= count_reg >= af_th;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    serial_shift_a: assert property (sclk_shift && !f_sel_n |=> bit_cnt_reg == $past(bit_cnt_reg) + 4'h1) else $error("serial bit not counted");
    serial_ignore_a: assert property (f_sel_n |=> bit_cnt_reg == 4'h0) else $error("serial count while deselected");
    serial_write_a: assert property (spi_commit && !eval_load |=> cfg_reg[$past(spi_word[11:8])] == $past(spi_word[7:0])) else $error("serial frame not stored");
    fifo_write_a: assert property (fifo_wr && !fifo_rd |=> count_reg == $past(count_reg) + 1'b1) else $error("fifo write lost");
    fifo_read_a: assert property (fifo_rd |=> data_out == $past(mem[rd_ptr_reg] & word_mask)) else $error("fifo read wrong word");
    par_idle_a: assert property (f_sel_n && !f_cfg_n && f_wen_n && f_ren_n |-> !fifo_wr && !fifo_rd && !par_wr && !par_rd && !sclk_shift) else $error("activity in idle config mode");
    width_mask_a: assert property (fifo_rd |=> (data_out & ~$past(word_mask)) == '0) else $error("bits above word width");
    depth_limit_a: assert property (count_reg <= limit && (full_flag == $past(count_reg >= limit))) else $error("fill beyond usable depth");
    eval_pick_a: assert property (w_term && !f_mr |=> eval_reg == PCS_EVAL_DONE && cfg_reg[`PCS_CFG_FAST][`PCS_FAST_BIT]) else $error("write clock win not loaded");
    eval_start_a: assert property (mr_fall |=> eval_reg == PCS_EVAL_COUNT && wcnt_reg == 10'h0 && rcnt_reg == 10'h0) else $error("evaluation not started");
    settle_eight_a: assert property (cfg_touch && !settle_done && !f_mr ##1 (!cfg_touch && !f_mr && !wclk_rise)[*2] |-> eff_reg[`PCS_CFG_FAST] == $past(eff_reg[`PCS_CFG_FAST], 2)) else $error("config acted early");
    settle_apply_a: assert property (settle_done && !f_mr |=> eff_reg[`PCS_CFG_FAST] == $past(cfg_reg[`PCS_CFG_FAST])) else $error("config not applied");
endmodule

// [test/pcs_host_model.sv]
// Purpose: host side model: free running port clocks, serial config master
// Assumes: bench sets the read clock half period
// Notes: serial clock moves only inside frames
`timescale 1ns/100ps
module pcs_host_model (
    // clock ratio control
    input  wire logic [7:0] rclk_half,
    // port clocks
    output logic            wclk,
    output logic            rclk,
    // serial port
    output logic            serial_clk,
    output logic            serial_select_n,
    output logic            serial_in
);
    initial begin
        wclk = 1'b0;
        rclk = 1'b0;
        serial_clk = 1'b0;
        serial_select_n = 1'b1;
        serial_in = 1'b0;
    end
    // free running, phase offset from system clock
    initial begin
        #3;
        forever #80 wclk = ~wclk;
    end
    initial begin
        #7;
        forever #(rclk_half) rclk = ~rclk;
    end
    // address byte then data byte, msb first
    task automatic frame(input logic [15:0] bits, input logic sel_n);
        serial_select_n = sel_n;
        for (int i = 15; i >= 0; i--) begin
            serial_in = bits[i];
            #80 serial_clk = 1'b1;
            #80 serial_clk = 1'b0;
        end
        serial_in = ~bits[0];
        #80 serial_select_n = 1'b1;
    endtask
endmodule

// [test/tb_top.sv]
// Purpose: self-checking bench for the fifo control block
// Assumes: host model makes port and serial clocks
// Notes: AW shrunk to 6 so full is reachable
`timescale 1ns/100ps
module tb_top;
    import pcs_fifo_pkg::*;
    // stimulus and observed signals
    logic        clk;
    logic        rst;
    logic        master_reset;
    logic        wclk;
    logic        rclk;
    logic        write_en_n;
    logic        read_en_n;
    logic        config_access_n;
    logic [2:0]  port_width_sel;
    logic        serial_clk;
    logic        serial_select_n;
    logic        serial_in;
    logic [35:0] data_in;
    logic [35:0] data_out;
    logic        empty_flag;
    logic        full_flag;
    logic        prog_almost_empty_flag;
    logic        prog_almost_full_flag;
    logic [35:0] data_out_hi;
    logic        empty_flag_hi;
    logic        full_flag_hi;
    logic        all_empty;
    logic        all_full;
    logic        fast_clk_is_write;
    logic [7:0]  rclk_half = 8'h64;
    int          n_mismatch = 0;
    int          checked = 0;
    int          cycles = 0;

    pcs_host_model i_host (.rclk_half, .wclk, .rclk, .serial_clk, .serial_select_n, .serial_in);

    pcs_fifo_ctrl #(.DATA_W(36), .AW(6)) i_dut (
        .clk, .rst, .master_reset, .wclk, .rclk, .write_en_n, .read_en_n,
        .config_access_n, .port_width_sel, .serial_clk, .serial_select_n, .serial_in,
        .data_in, .data_out, .empty_flag, .full_flag, .prog_almost_empty_flag,
        .prog_almost_full_flag, .fast_clk_is_write
    );

    // second device widens the word; every control input is shared
    pcs_fifo_ctrl #(.DATA_W(36), .AW(6)) i_dut_hi (
        .clk, .rst, .master_reset, .wclk, .rclk, .write_en_n, .read_en_n,
        .config_access_n, .port_width_sel, .serial_clk, .serial_select_n, .serial_in,
        .data_in(~data_in), .data_out(data_out_hi), .empty_flag(empty_flag_hi),
        .full_flag(full_flag_hi), .prog_almost_empty_flag(), .prog_almost_full_flag(),
        .fast_clk_is_write()
    );
    assign all_empty = empty_flag & empty_flag_hi;
    assign all_full  = full_flag & full_flag_hi;

    initial clk = 1'b0;
    always #10 clk = ~clk;

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 50000) begin
            n_mismatch = n_mismatch + 1;
            test_done();
        end
    end

    task automatic test_done();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check_bit(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic check_word(input string what, input logic [35:0] exp, input logic [35:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // enable held across exactly one port clock rise
    task automatic pulse_w(input logic [35:0] d);
        @(negedge wclk);
        @(negedge clk);
        data_in = d;
        write_en_n = 1'b0;
        @(negedge wclk);
        @(negedge clk);
        write_en_n = 1'b1;
        repeat (6) @(negedge clk);
    endtask

    task automatic pulse_r();
        @(negedge rclk);
        @(negedge clk);
        read_en_n = 1'b0;
        @(negedge rclk);
        @(negedge clk);
        read_en_n = 1'b1;
        repeat (6) @(negedge clk);
    endtask

    task automatic t_eval(input logic [2:0] code, input logic [7:0] half, input logic exp_fast);
        rclk_half = half;
        port_width_sel = code;
        repeat (4) @(negedge clk);
        master_reset = 1'b1;
        repeat (10) @(negedge clk);
        master_reset = 1'b0;
        repeat (20) @(negedge clk);
        port_width_sel = ~code;
        repeat (600) @(posedge wclk);
        check_bit("fast_clk_is_write", 1'b1, fast_clk_is_write);
        repeat (500) @(posedge wclk);
        check_bit("fast_clk_is_write", exp_fast, fast_clk_is_write);
        repeat (1024) @(posedge wclk);
        check_bit("empty_flag", 1'b1, empty_flag);
    endtask

    task automatic t_fill(input int n, input logic [35:0] base, input logic [35:0] mask);
        for (int i = 0; i < n; i++) begin
            check_bit("full_flag", 1'b0, full_flag);
            pulse_w(base + 36'(i));
        end
        check_bit("full_flag", 1'b1, full_flag);
        check_bit("all_full", 1'b1, all_full);
        check_bit("all_empty", 1'b0, all_empty);
        check_bit("prog_almost_full_flag", 1'b1, prog_almost_full_flag);
        pulse_w(36'h0_0000_01AA);
        for (int i = 0; i < n; i++) begin
            pulse_r();
            check_word("data_out", (base + 36'(i)) & mask, data_out);
            check_word("data_out_hi", ~(base + 36'(i)) & mask, data_out_hi);
        end
        check_bit("empty_flag", 1'b1, empty_flag);
        check_bit("all_empty", 1'b1, all_empty);
        check_bit("all_full", 1'b0, all_full);
        check_bit("prog_almost_empty_flag", 1'b1, prog_almost_empty_flag);
        pulse_r();
        check_word("data_out", (base + 36'(n - 1)) & mask, data_out);
    endtask

    task automatic t_serial();
        i_host.frame(16'h0A80, 1'b0);
        repeat (10) @(posedge wclk);
        check_bit("fast_clk_is_write", 1'b1, fast_clk_is_write);
        i_host.frame(16'h0A00, 1'b1);
        repeat (10) @(posedge wclk);
        check_bit("fast_clk_is_write", 1'b1, fast_clk_is_write);
    endtask

    task automatic t_par();
        logic [7:0] dflt [10] = '{8'h00, 8'h00, 8'h00, 8'h7F, 8'h00,
                                  8'h00, 8'h7F, 8'h00, 8'h00, 8'h80};
        @(negedge clk);
        config_access_n = 1'b0;
        repeat (4) @(posedge rclk);
        check_word("data_out", 36'h0_0000_0037, data_out);
        check_bit("empty_flag", 1'b1, empty_flag);
        for (int i = 0; i < 10; i++) begin
            pulse_r();
            check_word("data_out", {28'h000_0000, dflt[i]}, data_out);
        end
        config_access_n = 1'b1;
        repeat (4) @(negedge clk);
        config_access_n = 1'b0;
        for (int i = 0; i < 10; i++) begin
            pulse_w({28'h000_0000, (i == 9) ? 8'h00 : dflt[i]});
        end
        repeat (4) @(posedge wclk);
        check_bit("fast_clk_is_write", 1'b1, fast_clk_is_write);
        repeat (6) @(posedge wclk);
        check_bit("fast_clk_is_write", 1'b0, fast_clk_is_write);
        @(negedge clk);
        config_access_n = 1'b1;
    endtask

    initial begin
        rst = 1'b1;
        master_reset = 1'b0;
        write_en_n = 1'b1;
        read_en_n = 1'b1;
        config_access_n = 1'b1;
        port_width_sel = 3'b111;
        data_in = 36'h0_0000_0000;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        repeat (6) @(negedge clk);
        check_bit("fast_clk_is_write", 1'b1, fast_clk_is_write);
        check_word("data_out", 36'h0_0000_0000, data_out);
        t_eval(3'b000, 8'h3C, 1'b0);
        t_fill(56, 36'hF_FFFF_FE00, 36'h0_0000_01FF);
        t_serial();
        t_par();
        t_eval(3'b111, 8'h64, 1'b1);
        t_fill(8, 36'h9_8765_4320, 36'hF_FFFF_FFFF);
        test_done();
    end
endmodule
